// [shared/tcap_pkg.sv]
// Constants and types for the Type-C attach and PHY control block
// ============================================================
// Function
// - Three attach setups exist: external mux, internal modes 1 and 2.
// - External mux: a three-bit attach group gates the USB3 PHY clock.
// - The polarity pin sets the active level of attach and orient inputs.
// - A low or floating mux-mode select gives mode 1; it defaults low.
// - Mode 1 takes presence and orientation from two two-bit groups.
// - A high mux-mode select gives internal mode 2.
// - In mode 2 presence and orientation come from lane pairs A and B.
// - Internal modes enable only the matching PHY lane, others stay off.
`default_nettype none
package tcap_pkg;
  // ============================================================
  // Widths
  localparam int unsigned TCAP_EXT_ATT_W = 3;
  localparam int unsigned TCAP_INT_W = 2;
  localparam int unsigned TCAP_LANES = 2;
  localparam int unsigned TCAP_WARM_W = 3;
  // ============================================================
  // Lane indices
  localparam int unsigned TCAP_LANE_A = 0;
  localparam int unsigned TCAP_LANE_B = 1;
  // ============================================================
  // Reset values and warm-up step
  localparam logic [TCAP_LANES-1:0] TCAP_LANE_OFF = 2'h0;
  localparam logic TCAP_BIT_RST = 1'h0;
  localparam logic [TCAP_WARM_W-1:0] TCAP_WARM_RST = 3'h0;
  localparam logic [TCAP_WARM_W-1:0] TCAP_WARM_STEP = 3'h1;
  // Synchroniser edges until pin levels reach the decode
  localparam logic [TCAP_WARM_W-1:0] TCAP_WARM_DONE = 3'h4;
  // ============================================================
  // Attach configurations
  typedef enum logic [1:0] {
    TCAP_CFG_EXT = 2'h0,
    TCAP_CFG_MODE1 = 2'h1,
    TCAP_CFG_MODE2 = 2'h2
  } tcap_cfg_t;
endpackage
`default_nettype wire

// [design/tcap_sync.sv]
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module tcap_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import tcap_pkg::*;
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } tcap_sync_st_t;
  tcap_sync_st_t st_q;
  tcap_sync_st_t st_d;
  // ============================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Change taken once stages two and three agree
    for (int i = 0; i < int'(W); i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.val[i] = st_q.s3[i];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign sync_out = st_q.val;
endmodule
`default_nettype wire

// [design/tcap_phy_ctrl.sv]
// Type-C attach decode and USB3 PHY lane and clock control
`timescale 1ns/1ps
`default_nettype none
module tcap_phy_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Board-level configuration
  input wire logic ext_mux_sel,
  input wire logic mux_mode_sel,
  input wire logic input_polarity_sel,
  // Attach inputs from the Type-C controller
  input wire logic [tcap_pkg::TCAP_EXT_ATT_W-1:0] ext_attach_in,
  input wire logic [tcap_pkg::TCAP_INT_W-1:0] c_attach_in,
  input wire logic [tcap_pkg::TCAP_INT_W-1:0] orient_sel_in,
  input wire logic [tcap_pkg::TCAP_INT_W-1:0] lane_attach_in_a,
  input wire logic [tcap_pkg::TCAP_INT_W-1:0] lane_attach_in_b,
  // PHY control
  output logic phy_clk_en,
  output logic [tcap_pkg::TCAP_LANES-1:0] phy_lane_en,
  output logic attached,
  output logic orient_flip,
  output tcap_pkg::tcap_cfg_t cfg_mode
);
  import tcap_pkg::*;

  typedef struct packed {
    tcap_cfg_t cfg;
    logic clk_en;
    logic [TCAP_LANES-1:0] lane_en;
    logic att;
    logic flip;
    logic [TCAP_WARM_W-1:0] warm;
  } tcap_st_t;

  tcap_st_t st_q;
  tcap_st_t st_d;
  logic s_ext;
  logic s_mode;
  logic s_pol;
  logic [TCAP_EXT_ATT_W-1:0] s_ext_att;
  logic [TCAP_INT_W-1:0] s_att;
  logic [TCAP_INT_W-1:0] s_ori;
  logic [TCAP_INT_W-1:0] s_la;
  logic [TCAP_INT_W-1:0] s_lb;
  logic [TCAP_EXT_ATT_W-1:0] p_ext_att;
  logic [TCAP_INT_W-1:0] p_att;
  logic [TCAP_INT_W-1:0] p_ori;
  logic [TCAP_INT_W-1:0] p_la;
  logic [TCAP_INT_W-1:0] p_lb;
  logic ext_att_any;
  logic m1_att;
  logic m1_flip;
  logic m2_a_any;
  logic m2_b_any;
  logic warm_done;

  // ============================================================
  // Input synchronisers, one per pin group
  tcap_sync #(
    .W(1)
  ) u_sync_ext (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(ext_mux_sel),
    .sync_out(s_ext)
  );

  tcap_sync #(
    .W(1)
  ) u_sync_mode (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(mux_mode_sel),
    .sync_out(s_mode)
  );

  tcap_sync #(
    .W(1)
  ) u_sync_pol (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(input_polarity_sel),
    .sync_out(s_pol)
  );

  tcap_sync #(
    .W(TCAP_EXT_ATT_W)
  ) u_sync_ext_att (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(ext_attach_in),
    .sync_out(s_ext_att)
  );

  tcap_sync #(
    .W(TCAP_INT_W)
  ) u_sync_att (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(c_attach_in),
    .sync_out(s_att)
  );

  tcap_sync #(
    .W(TCAP_INT_W)
  ) u_sync_ori (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(orient_sel_in),
    .sync_out(s_ori)
  );

  tcap_sync #(
    .W(TCAP_INT_W)
  ) u_sync_la (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(lane_attach_in_a),
    .sync_out(s_la)
  );

  tcap_sync #(
    .W(TCAP_INT_W)
  ) u_sync_lb (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(lane_attach_in_b),
    .sync_out(s_lb)
  );

  // ============================================================
  // Polarity: low select means inputs are active low
  assign p_ext_att = s_pol ? s_ext_att : ~s_ext_att;
  assign p_att = s_pol ? s_att : ~s_att;
  assign p_ori = s_pol ? s_ori : ~s_ori;
  assign p_la = s_pol ? s_la : ~s_la;
  assign p_lb = s_pol ? s_lb : ~s_lb;

  // ============================================================
  // Group presence, any active bit counts
  assign ext_att_any = |p_ext_att;
  assign m1_att = |p_att;
  assign m1_flip = m1_att & (|p_ori);
  assign m2_a_any = |p_la;
  assign m2_b_any = |p_lb;

  // ============================================================
  // Warm-up: cleared synchronisers would read as active-low attach
  assign warm_done = (st_q.warm == TCAP_WARM_DONE);

  // ============================================================
  // Decode
  always_comb begin
    st_d = st_q;
    // Outputs keep reset values until real pin levels arrive
    if (!warm_done) begin
      st_d.warm = st_q.warm + TCAP_WARM_STEP;
    end else begin
      if (s_ext) begin
        st_d.cfg = TCAP_CFG_EXT;
      end else if (s_mode) begin
        st_d.cfg = TCAP_CFG_MODE2;
      end else begin
        // Floating select reads low through the board pull-down
        st_d.cfg = TCAP_CFG_MODE1;
      end
      st_d.att = TCAP_BIT_RST;
      st_d.flip = TCAP_BIT_RST;
      st_d.clk_en = TCAP_BIT_RST;
      st_d.lane_en = TCAP_LANE_OFF;
      unique case (st_d.cfg)
        TCAP_CFG_EXT: begin
          // Any attach line running keeps the PHY clock on
          st_d.att = ext_att_any;
          st_d.clk_en = ext_att_any;
          st_d.lane_en[TCAP_LANE_A] = ext_att_any;
        end
        TCAP_CFG_MODE1: begin
          st_d.att = m1_att;
          st_d.flip = m1_flip;
        end
        TCAP_CFG_MODE2: begin
          // Lane B pair alone marks the flipped orientation
          st_d.att = m2_a_any | m2_b_any;
          st_d.flip = m2_b_any & ~m2_a_any;
        end
        default: begin
          st_d.att = TCAP_BIT_RST;
        end
      endcase
      // Internal mux: clock and one lane follow attach and orientation
      if (st_d.cfg != TCAP_CFG_EXT) begin
        st_d.clk_en = st_d.att;
        st_d.lane_en[TCAP_LANE_A] = st_d.att & ~st_d.flip;
        st_d.lane_en[TCAP_LANE_B] = st_d.att & st_d.flip;
      end
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '{cfg: TCAP_CFG_MODE1,
                clk_en: TCAP_BIT_RST,
                lane_en: TCAP_LANE_OFF,
                att: TCAP_BIT_RST,
                flip: TCAP_BIT_RST,
                warm: TCAP_WARM_RST};
    end else begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // Outputs
  assign phy_clk_en = st_q.clk_en;
  assign phy_lane_en = st_q.lane_en;
  assign attached = st_q.att;
  assign orient_flip = st_q.flip;
  assign cfg_mode = st_q.cfg;
endmodule
`default_nettype wire

// [dv/tcap_far_model.sv]
// Behavioural Type-C port controller driving attach lines
`timescale 1ns/1ps
`default_nettype none
module tcap_far_model (
  // Command from the bench
  input wire logic pol,
  input wire logic att,
  input wire logic flip,
  // Attach lines to the block
  output logic [2:0] ext_attach_in,
  output logic [1:0] c_attach_in,
  output logic [1:0] orient_sel_in,
  output logic [1:0] lane_attach_in_a,
  output logic [1:0] lane_attach_in_b
);
  // ============================================================
  // Active level follows polarity, orientation only when attached
  always_comb begin
    ext_attach_in = {2'h0, att} ^ {3{~pol}};
    c_attach_in = {1'h0, att} ^ {2{~pol}};
    orient_sel_in = {1'h0, att & flip} ^ {2{~pol}};
    lane_attach_in_a = {1'h0, att & ~flip} ^ {2{~pol}};
    lane_attach_in_b = {1'h0, att & flip} ^ {2{~pol}};
  end
endmodule
`default_nettype wire

// [dv/tcap_phy_ctrl_chk.sv]
// Checker for the Type-C attach and PHY control outputs
`timescale 1ns/1ps
`default_nettype none
module tcap_phy_ctrl_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs
  input wire logic ext_mux_sel,
  input wire logic mux_mode_sel,
  input wire logic input_polarity_sel,
  input wire logic [2:0] ext_attach_in,
  input wire logic [1:0] c_attach_in,
  input wire logic [1:0] orient_sel_in,
  input wire logic [1:0] lane_attach_in_a,
  input wire logic [1:0] lane_attach_in_b,
  // Outputs
  input wire logic phy_clk_en,
  input wire logic [1:0] phy_lane_en,
  input wire logic attached,
  input wire logic orient_flip,
  input wire tcap_pkg::tcap_cfg_t cfg_mode
);
  import tcap_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ============================================================
  // Properties
  sequence s_quiet;
    $stable({ext_mux_sel, mux_mode_sel, input_polarity_sel, ext_attach_in,
      c_attach_in, orient_sel_in, lane_attach_in_a, lane_attach_in_b})[*8];
  endsequence
  property p_hold;
    s_quiet |-> $stable({attached, phy_lane_en});
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved");
  property p_one;
    phy_lane_en != 2'h3;
  endproperty
  a_one: assert property (p_one) else $error("two lanes on");
  property p_ext;
    cfg_mode == TCAP_CFG_EXT |-> phy_lane_en == {1'b0, phy_clk_en};
  endproperty
  a_ext: assert property (p_ext) else $error("ext lane bad");
  property p_clk;
    cfg_mode != TCAP_CFG_EXT |-> phy_clk_en == attached;
  endproperty
  a_clk: assert property (p_clk) else $error("clock gate bad");
  property p_lane;
    cfg_mode != TCAP_CFG_EXT |->
      phy_lane_en == {attached & orient_flip, attached & ~orient_flip};
  endproperty
  a_lane: assert property (p_lane) else $error("lane pick bad");
  property p_m1;
    (!ext_mux_sel && !mux_mode_sel)[*6] |-> cfg_mode == TCAP_CFG_MODE1;
  endproperty
  a_m1: assert property (p_m1) else $error("mode1 bad");
  property p_m2;
    (!ext_mux_sel && mux_mode_sel)[*6] |-> cfg_mode == TCAP_CFG_MODE2;
  endproperty
  a_m2: assert property (p_m2) else $error("mode2 bad");
  property p_ec;
    ext_mux_sel[*6] |-> cfg_mode == TCAP_CFG_EXT;
  endproperty
  a_ec: assert property (p_ec) else $error("ext cfg bad");
endmodule
bind tcap_phy_ctrl tcap_phy_ctrl_chk tcap_phy_ctrl_chk_inst (.*);
`default_nettype wire

// [dv/tcap_phy_ctrl_tb.sv]
// Self-checking bench for the Type-C attach and PHY control block
`timescale 1ns/1ps
`default_nettype none
module tcap_phy_ctrl_tb;
  import tcap_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, e_s = 1'b0, m_s = 1'b0;
  logic pol = 1'b1, att = 1'b0, flip = 1'b0, clk_en, attd, flp;
  logic [2:0] ext_att;
  logic [1:0] c_att, ori, l_a, l_b, lanes;
  tcap_cfg_t cfg;
  int failures = 0, samples_checked = 0;
  wire logic [6:0] got = {cfg, attd, flp, lanes, clk_en};
  always #12.5 mclk = ~mclk;
  tcap_far_model tcap_far_model_inst (.pol(pol), .att(att), .flip(flip),
    .ext_attach_in(ext_att), .c_attach_in(c_att), .orient_sel_in(ori),
    .lane_attach_in_a(l_a), .lane_attach_in_b(l_b));
  tcap_phy_ctrl tcap_phy_ctrl_inst (.mclk(mclk), .rst_n(rst_n),
    .ext_mux_sel(e_s), .mux_mode_sel(m_s), .input_polarity_sel(pol),
    .ext_attach_in(ext_att), .c_attach_in(c_att), .orient_sel_in(ori),
    .lane_attach_in_a(l_a), .lane_attach_in_b(l_b), .phy_clk_en(clk_en),
    .phy_lane_en(lanes), .attached(attd), .orient_flip(flp), .cfg_mode(cfg));
  // ============================================================
  // Tasks
  task automatic compare(input logic [6:0] exp, input logic [6:0] act);
    samples_checked++;
    if (act !== exp) begin
      failures++;
      $display("mismatch at %0t exp %h got %h", $time, exp, act);
    end
  endtask
  task automatic drive(input logic e, m, p, a, f);
    @(posedge mclk);
    {e_s, m_s, pol, att, flip} <= {e, m, p, a, f};
  endtask
  task automatic run(input logic e, m);
    logic [1:0] c;
    for (int k = 0; k < 8; k++) begin
      drive(e, m, k[2], k[1], k[0]);
      repeat (7) @(posedge mclk);
      #1;
      c = e ? 2'h0 : (m ? 2'h2 : 2'h1);
      compare({c, k[1], k[1] & k[0] & ~e, e ? {1'b0, k[1]} :
        {k[1] & k[0], k[1] & ~k[0]}, k[1]}, got);
    end
  endtask
  task automatic glitch();
    drive(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    repeat (7) @(posedge mclk);
    drive(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    drive(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    repeat (8) begin
      @(posedge mclk);
      #1;
      compare(7'h20, got);
    end
  endtask
  task automatic reset_check();
    drive(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) begin
      @(posedge mclk);
      #1;
      compare(7'h20, got);
    end
  endtask
  task automatic summarize();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ============================================================
  // Sequence and watchdog
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    run(1'b1, 1'b0);
    run(1'b0, 1'b0);
    run(1'b0, 1'b1);
    reset_check();
    glitch();
    summarize();
  end
  initial begin
    #50000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
